// File: design/sim_irq_ctrl.sv
// Purpose: interrupt sequencing, status registers, break protection, wait control
// Assumes: core reports boundaries and instruction events as one-cycle pulses
// Notes  : one-cycle wishbone ack; flags are live request lines
//
// The implementer's own choices: the Wishbone interface to the registers and the address map.

`timescale 1ns/1ps

module sim_irq_ctrl #(
    parameter int NSRC = sim_irq_pkg::N_SRC
) (
    input  wire logic               clk_sys,
    input  wire logic               reset_n,
    input  wire logic               any_reset_req,
    input  wire logic               rst_pin_req,
    input  wire logic               break_req,
    input  wire logic               global_mask,
    input  wire logic [NSRC-1:0]    src_req,
    input  wire logic [NSRC-1:0]    src_en,
    input  wire sim_irq_pkg::core_req_s core_req,
    output sim_irq_pkg::core_ctl_s  core_ctl,
    output logic                    lowpower_exit,
    output logic                    flag_clear_allow,
    output logic                    watchdog_run,
    output logic                    break_mode,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic [31:0]             wb_dat_o,
    output logic                    wb_ack_o
);

    // ========================================================================
    // priority pick
    // ========================================================================
    // index 0 is flag 1; lower index always wins
    function automatic logic [4:0] pick(input logic [NSRC-1:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = 5'(i);
            end
        end
        return r;
    endfunction : pick

    sim_irq_pkg::state_s r_ff;
    sim_irq_pkg::state_s nxt_r;
    logic [NSRC-1:0] live;
    logic             hw_any;
    logic             wb_hit;
    logic             brk_pend;

    assign live     = src_req & src_en;
    assign hw_any   = |live;
    assign wb_hit   = wb_cyc_i & wb_stb_i & ~r_ff.ack;
    // break is a level; it asks for one entry only, until it drops again
    assign brk_pend = break_req & ~r_ff.break_done;

    // ========================================================================
    // sequencing
    // ========================================================================
    always_comb
    begin
        nxt_r = r_ff;
        nxt_r.ack = wb_hit;
        nxt_r.break_done = r_ff.break_done & break_req;
        nxt_r.ctl.take = 1'b0;
        nxt_r.ctl.set_mask = 1'b0;
        nxt_r.ctl.clr_mask = 1'b0;
        nxt_r.ctl.restore = 1'b0;
        nxt_r.ctl.discard_prefetch = 1'b0;
        nxt_r.ctl.stack_hi_index = 1'b0;
        nxt_r.ctl.periph_clk_en = 1'b1;
        nxt_r.ctl.core_clk_en = 1'b1;
        if (r_ff.mode == sim_irq_pkg::ST_STOP)
        begin
            nxt_r.ctl.periph_clk_en = 1'b0;
        end
        case (r_ff.mode)
            sim_irq_pkg::ST_RUN, sim_irq_pkg::ST_SERVE:
            begin
                if (core_req.ret_done)
                begin
                    nxt_r.ctl.restore = 1'b1;
                    nxt_r.mode = sim_irq_pkg::ST_RUN;
                end
                if (brk_pend || core_req.trap_exec)
                begin
                    nxt_r.latched = 1'b1;
                    nxt_r.is_trap = 1'b1;
                    nxt_r.break_done = break_req;
                    nxt_r.mode = sim_irq_pkg::ST_ENTRY;
                end
                else if (core_req.wait_exec || core_req.stop_exec)
                begin
                    nxt_r.ctl.clr_mask = 1'b1;
                    nxt_r.ctl.core_clk_en = 1'b0;
                    nxt_r.mode = core_req.stop_exec ? sim_irq_pkg::ST_STOP : sim_irq_pkg::ST_WAIT;
                end
                else if ((core_req.instr_done || core_req.ret_done) && !global_mask && hw_any)
                begin
                    nxt_r.latched = 1'b1;
                    nxt_r.is_trap = 1'b0;
                    nxt_r.src = pick(live);
                    nxt_r.ctl.discard_prefetch = core_req.ret_done;
                    nxt_r.mode = sim_irq_pkg::ST_ENTRY;
                end
            end
            sim_irq_pkg::ST_WAIT, sim_irq_pkg::ST_STOP:
            begin
                nxt_r.ctl.core_clk_en = 1'b0;
                if (brk_pend)
                begin
                    nxt_r.lowpwr_break = 1'b1;
                    nxt_r.latched = 1'b1;
                    nxt_r.is_trap = 1'b1;
                    nxt_r.break_done = 1'b1;
                    nxt_r.mode = sim_irq_pkg::ST_ENTRY;
                end
                else if (hw_any)
                begin
                    nxt_r.latched = 1'b1;
                    nxt_r.is_trap = 1'b0;
                    nxt_r.src = pick(live);
                    nxt_r.mode = sim_irq_pkg::ST_ENTRY;
                end
            end
            sim_irq_pkg::ST_ENTRY:
            begin
                // latched choice held; no re-arbitration here
                nxt_r.ctl.take = 1'b1;
                nxt_r.ctl.set_mask = 1'b1;
                nxt_r.ctl.vector = r_ff.is_trap ? sim_irq_pkg::VEC_TRAP
                    : sim_irq_pkg::VEC_IF1 - 16'(r_ff.src) * sim_irq_pkg::VEC_STEP;
                nxt_r.ctl.stack_pc = r_ff.is_trap ? core_req.pc
                    : core_req.pc - sim_irq_pkg::PC_DEC;
                nxt_r.latched = 1'b0;
                nxt_r.mode = sim_irq_pkg::ST_SERVE;
            end
            default:
            begin
                nxt_r.mode = sim_irq_pkg::ST_RUN;
            end
        endcase

        // register writes; flag registers ignore writes
        if (wb_hit && wb_we_i && wb_sel_i[0])
        begin
            if (wb_adr_i == sim_irq_pkg::OFS_BREAK_CTRL)
            begin
                nxt_r.clear_en = wb_dat_i[sim_irq_pkg::BIT_CLEAR_EN];
            end
            else if (wb_adr_i == sim_irq_pkg::OFS_CORE_CTRL)
            begin
                nxt_r.wdog_dis = wb_dat_i[sim_irq_pkg::BIT_WDOG_DIS];
            end
            else if (wb_adr_i == sim_irq_pkg::OFS_BREAK_STATE && !wb_dat_i[sim_irq_pkg::BIT_LOWPWR_BREAK])
            begin
                // a break landing in wait in this same cycle keeps the flag set
                nxt_r.lowpwr_break = brk_pend && (r_ff.mode inside {sim_irq_pkg::ST_WAIT, sim_irq_pkg::ST_STOP});
            end
        end

        nxt_r.rdata = sim_irq_pkg::READ_ZERO;
        if (wb_adr_i == sim_irq_pkg::OFS_FLAGS_LOW)
        begin
            nxt_r.rdata = {src_req[sim_irq_pkg::MID_BASE-1:0], 2'b00};
        end
        else if (wb_adr_i == sim_irq_pkg::OFS_FLAGS_MID)
        begin
            nxt_r.rdata = src_req[sim_irq_pkg::MID_BASE +: 8];
        end
        else if (wb_adr_i == sim_irq_pkg::OFS_FLAGS_HIGH)
        begin
            nxt_r.rdata = src_req[sim_irq_pkg::HIGH_BASE +: 8];
        end
        else if (wb_adr_i == sim_irq_pkg::OFS_BREAK_STATE)
        begin
            nxt_r.rdata[sim_irq_pkg::BIT_LOWPWR_BREAK] = r_ff.lowpwr_break;
        end
        else if (wb_adr_i == sim_irq_pkg::OFS_BREAK_CTRL)
        begin
            nxt_r.rdata[sim_irq_pkg::BIT_CLEAR_EN] = r_ff.clear_en;
        end
        else if (wb_adr_i == sim_irq_pkg::OFS_CORE_CTRL)
        begin
            nxt_r.rdata[sim_irq_pkg::BIT_WDOG_DIS] = r_ff.wdog_dis;
        end

        if (any_reset_req)
        begin
            // reset outranks everything, wait included
            nxt_r.mode = sim_irq_pkg::ST_RUN;
            nxt_r.latched = 1'b0;
            nxt_r.ctl.take = 1'b1;
            nxt_r.ctl.vector = sim_irq_pkg::VEC_RESET;
            nxt_r.ctl.core_clk_en = 1'b1;
            nxt_r.ctl.periph_clk_en = 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            r_ff <= '0;
            r_ff.ctl.core_clk_en <= 1'b1;
            r_ff.ctl.periph_clk_en <= 1'b1;
            r_ff.ctl.vector <= sim_irq_pkg::VEC_RESET;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    // ========================================================================
    // outputs
    // ========================================================================
    assign core_ctl = r_ff.ctl;
    assign wb_ack_o = r_ff.ack;
    assign wb_dat_o = {24'h000000, r_ff.rdata};
    assign lowpower_exit = rst_pin_req | hw_any;
    assign break_mode = break_req;
    // two-step clears are blocked as a whole, so a half-done one survives
    assign flag_clear_allow = ~break_req | r_ff.clear_en;
    assign watchdog_run = ~r_ff.wdog_dis;

endmodule : sim_irq_ctrl

// File: design/sim_irq_pkg.sv
// Purpose: constants and carriers for the interrupt and wait control unit
// Assumes: 8-bit registers in the low bits of a 32-bit classic wishbone word
// Notes  : vector addresses are the low byte of each two-byte vector pair
//
// Summary of operation
// - hardware interrupts start at an instruction boundary signalled by the core, or at once in wait or stop
// - service only when global mask clear and the source enable is set
// - several pending requests: the highest fixed priority is serviced first
// - request pending at handler return is serviced before next program instruction
// - interrupt entry never stacks the high index byte
// - software trap and break ignore the global mask; mask gates the hardware sources
// - software trap stacks pc, hardware interrupt stacks pc minus one
// - fixed priority order with descending two-byte vectors, reset FFFE to FFD0
// - any reset beats all interrupts, resets are never arbitrated
// - each maskable source drives its own numbered pending flag
// - low status register holds flags 1 to 6 in upper bits, bits 0-1 zero
// - mid register holds flags 7 to 14, high register flags 15 to 22
// - break request vectors the core to the software trap vector
// - break without clear enable blocks peripheral flag clearing
// - break with clear enable allows clearing, cleared flags stay cleared
// - two-step clearing protected in break even if first step came before
// - wait or stop clears global mask and holds the core unclocked
// - wait gates core clock while peripheral clocks keep running
// - enabled interrupt wakes wait; stacking starts two cycles after arrival
// - wait ends on reset or break; break in wait sets low-power break flag
// - watchdog stays running in wait while its disable bit is zero
// - low-power exit is reset pin request or any core interrupt request
// - a latched interrupt is not preempted until serviced or a reset drops it
// - entry saves registers and sets mask; return restores them

package sim_irq_pkg;

    // ========================================================================
    // sources and register map
    // ========================================================================
    localparam int N_SRC = 22;
    localparam logic [7:0] OFS_FLAGS_LOW   = 8'h00;
    localparam logic [7:0] OFS_FLAGS_MID   = 8'h04;
    localparam logic [7:0] OFS_FLAGS_HIGH  = 8'h08;
    localparam logic [7:0] OFS_BREAK_STATE = 8'h0C;
    localparam logic [7:0] OFS_BREAK_CTRL  = 8'h10;
    localparam logic [7:0] OFS_CORE_CTRL   = 8'h14;
    localparam int BIT_LOWPWR_BREAK = 1;
    localparam int BIT_CLEAR_EN     = 7;
    localparam int BIT_WDOG_DIS     = 0;
    localparam int LOW_SHIFT        = 2;
    localparam int MID_BASE         = 6;
    localparam int HIGH_BASE        = 14;
    localparam logic [15:0] VEC_RESET = 16'hFFFE;
    localparam logic [15:0] VEC_TRAP  = 16'hFFFC;
    localparam logic [15:0] VEC_IF1   = 16'hFFFA;
    localparam logic [15:0] VEC_STEP  = 16'h0002;
    localparam logic [15:0] PC_DEC    = 16'h0001;
    localparam logic [7:0]  READ_ZERO = 8'h00;

    typedef enum logic [2:0] {
        ST_RUN   = 3'b000,
        ST_ENTRY = 3'b001,
        ST_SERVE = 3'b011,
        ST_WAIT  = 3'b010,
        ST_STOP  = 3'b110
    } mode_e;

    // ========================================================================
    // carriers
    // ========================================================================
    typedef struct packed {
        logic        instr_done;
        logic        ret_done;
        logic        wait_exec;
        logic        stop_exec;
        logic        trap_exec;
        logic [15:0] pc;
    } core_req_s;

    typedef struct packed {
        logic        take;
        logic [15:0] vector;
        logic [15:0] stack_pc;
        logic        stack_hi_index;
        logic        set_mask;
        logic        clr_mask;
        logic        restore;
        logic        discard_prefetch;
        logic        core_clk_en;
        logic        periph_clk_en;
    } core_ctl_s;

    typedef struct packed {
        mode_e               mode;
        logic                latched;
        logic [4:0]          src;
        logic                is_trap;
        logic                clear_en;
        logic                lowpwr_break;
        logic                wdog_dis;
        logic                break_done;
        logic                ack;
        logic [7:0]          rdata;
        core_ctl_s           ctl;
    } state_s;

endpackage : sim_irq_pkg

// File: testbench/irq_ctrl_monitor.sv
// Purpose: port checker for sim_irq_ctrl
// Assumes: core pc held steady around hardware entries
// Notes  : bound to the design after the module
`timescale 1ns/1ps
module irq_ctrl_monitor #(
    parameter int NSRC = sim_irq_pkg::N_SRC
) (
    input wire logic                   clk_sys,
    input wire logic                   reset_n,
    input wire logic                   any_reset_req,
    input wire logic                   rst_pin_req,
    input wire logic                   break_req,
    input wire logic                   global_mask,
    input wire logic [NSRC-1:0]        src_req,
    input wire logic [NSRC-1:0]        src_en,
    input wire sim_irq_pkg::core_req_s core_req,
    input wire sim_irq_pkg::core_ctl_s core_ctl,
    input wire logic                   lowpower_exit,
    input wire logic                   flag_clear_allow,
    input wire logic                   wb_cyc_i,
    input wire logic                   wb_stb_i,
    input wire logic                   wb_we_i,
    input wire logic [7:0]             wb_adr_i,
    input wire logic [31:0]            wb_dat_o,
    input wire logic                   wb_ack_o
);
    // ========================================================================
    // properties
    // ========================================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence bus_req_q; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence ack_pulse_q; wb_ack_o ##1 !wb_ack_o; endsequence
    sequence trap_entry_q; core_ctl.take && core_ctl.vector == sim_irq_pkg::VEC_TRAP; endsequence
    bus_answer_a: assert property (bus_req_q |=> ack_pulse_q) else $error("bus ack not one cycle");
    no_hi_stack_a: assert property (!core_ctl.stack_hi_index) else $error("high index stacked");
    exit_or_a: assert property (lowpower_exit == (rst_pin_req || |(src_req & src_en)))
        else $error("lowpower exit wrong");
    take_gate_a: assert property (core_req.instr_done && !global_mask && |(src_req & src_en) && !break_req
        && !any_reset_req && core_ctl.core_clk_en && !core_ctl.take |-> ##2 core_ctl.take)
        else $error("enabled request not taken");
    trap_vec_a: assert property (core_req.trap_exec |-> ##[1:3] trap_entry_q)
        else $error("trap not vectored");
    break_vec_a: assert property ($rose(break_req) |-> ##[1:3] trap_entry_q)
        else $error("break not vectored");
    hw_stack_a: assert property (core_ctl.take && core_ctl.vector < sim_irq_pkg::VEC_TRAP
        |-> core_ctl.stack_pc == core_req.pc - sim_irq_pkg::PC_DEC) else $error("stacked pc wrong");
    wait_entry_a: assert property (core_req.wait_exec |=> core_ctl.clr_mask && !core_ctl.core_clk_en
        && core_ctl.periph_clk_en) else $error("wait entry wrong");
    reset_vec_a: assert property (any_reset_req |=> core_ctl.vector == sim_irq_pkg::VEC_RESET
        && core_ctl.take) else $error("reset vector not forced");
    low_flags_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == sim_irq_pkg::OFS_FLAGS_LOW
        |-> wb_dat_o == {24'h0, src_req[5:0], 2'b00}) else $error("low flags wrong");
    clear_allow_a: assert property (!break_req |-> flag_clear_allow) else $error("clearing blocked");
endmodule : irq_ctrl_monitor

bind sim_irq_ctrl irq_ctrl_monitor #(.NSRC(NSRC)) mon (.clk_sys(clk_sys), .reset_n(reset_n),
    .any_reset_req(any_reset_req), .rst_pin_req(rst_pin_req), .break_req(break_req),
    .global_mask(global_mask), .src_req(src_req), .src_en(src_en), .core_req(core_req),
    .core_ctl(core_ctl), .lowpower_exit(lowpower_exit), .flag_clear_allow(flag_clear_allow),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

// File: testbench/core_model.sv
// Purpose: processor core stand-in holding the global mask bit
// Assumes: bench supplies instruction events as one-cycle pulses
// Notes  : ev[5] is a mask-clearing instruction, never seen by the unit
`timescale 1ns/1ps
module core_model (
    input  wire logic                   clk_sys,
    input  wire logic                   reset_n,
    input  wire logic [5:0]             ev,
    input  wire logic [15:0]            pc,
    input  wire sim_irq_pkg::core_ctl_s core_ctl,
    output sim_irq_pkg::core_req_s      core_req,
    output logic                        global_mask
);
    logic mask_ff;
    assign core_req = {ev[4:0], pc};
    // a return reports its boundary with the stacked, clear mask already back
    assign global_mask = mask_ff & ~ev[3];
    // masked out of reset, as a real core is
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            mask_ff <= 1'b1;
        else if (core_ctl.set_mask)
            mask_ff <= 1'b1;
        else if (core_ctl.clr_mask || core_ctl.restore || ev[5])
            mask_ff <= 1'b0;
    end
endmodule : core_model

// File: testbench/sim_irq_ctrl_test.sv
// Purpose: self-checking bench for sim_irq_ctrl
// Assumes: one-cycle wishbone ack, core model at the far side
// Notes  : pc held at one value so stacked values are known
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module sim_irq_ctrl_test;
    logic        clk_sys = 1'b0, reset_n = 1'b0, any_reset_req = 1'b0, rst_pin_req = 1'b0, break_req = 1'b0;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, global_mask, lowpower_exit, flag_clear_allow;
    logic        watchdog_run, break_mode, ack, disc;
    logic [5:0]  ev = 6'h0;
    logic [7:0]  adr = 8'h0;
    logic [31:0] wdat = 32'h0, rdat, wb_dat_o;
    logic [21:0] src_req = 22'h0, src_en = 22'h3FFFFF;
    logic [15:0] pc = 16'h1234;
    sim_irq_pkg::core_req_s core_req;
    sim_irq_pkg::core_ctl_s core_ctl;
    int          fails = 0, num_checks = 0;
    always #2.5 clk_sys = ~clk_sys;
    core_model core (.clk_sys(clk_sys), .reset_n(reset_n), .ev(ev), .pc(pc), .core_ctl(core_ctl),
        .core_req(core_req), .global_mask(global_mask));
    sim_irq_ctrl dut (.clk_sys(clk_sys), .reset_n(reset_n), .any_reset_req(any_reset_req),
        .rst_pin_req(rst_pin_req), .break_req(break_req), .global_mask(global_mask), .src_req(src_req),
        .src_en(src_en), .core_req(core_req), .core_ctl(core_ctl), .lowpower_exit(lowpower_exit),
        .flag_clear_allow(flag_clear_allow), .watchdog_run(watchdog_run), .break_mode(break_mode),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
        .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(ack));
    // ========================================================================
    // tasks
    // ========================================================================
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, w, a, d};
        do begin @(posedge clk_sys); n++; end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) fails++;
        rdat = wb_dat_o;
        {cyc, stb, we} <= 3'h0;
        @(posedge clk_sys);
    endtask : wb
    task automatic pulse(input logic [5:0] e);
        ev <= e;
        @(posedge clk_sys);
        ev <= 6'h0;
        @(posedge clk_sys);
    endtask : pulse
    // stacked pc of zero means the entry kind leaves it open
    task automatic take(input logic [15:0] vec, input logic [15:0] spc);
        int n;
        n = 0;
        disc = core_ctl.discard_prefetch;
        do begin @(posedge clk_sys); n++; disc |= core_ctl.discard_prefetch; end
        while (core_ctl.take !== 1'b1 && n < 12);
        `CHK(core_ctl.take, 1'b1)
        `CHK(core_ctl.vector, vec)
        if (spc != 16'h0) `CHK(core_ctl.stack_pc, spc)
        @(posedge clk_sys);
    endtask : take
    task automatic end_sim;
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_sim
    // ========================================================================
    // scenarios
    // ========================================================================
    initial
    begin
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        src_req <= 22'h2D5A4;
        @(posedge clk_sys);
        wb(1'b0, sim_irq_pkg::OFS_FLAGS_LOW, 32'h0);  `CHK(rdat, {24'h0, src_req[5:0], 2'b00})
        wb(1'b0, sim_irq_pkg::OFS_FLAGS_MID, 32'h0);  `CHK(rdat, {24'h0, src_req[13:6]})
        wb(1'b0, sim_irq_pkg::OFS_FLAGS_HIGH, 32'h0); `CHK(rdat, {24'h0, src_req[21:14]})
        wb(1'b1, sim_irq_pkg::OFS_FLAGS_MID, 32'hFF);
        wb(1'b0, sim_irq_pkg::OFS_FLAGS_MID, 32'h0);  `CHK(rdat, {24'h0, src_req[13:6]})
        wb(1'b0, 8'h20, 32'h0);                       `CHK(rdat, 32'h0)
        {src_en, rst_pin_req} <= {22'h0, 1'b1};
        @(posedge clk_sys);
        #1 `CHK(lowpower_exit, 1'b1)
        @(posedge clk_sys);
        {src_en, rst_pin_req, src_req} <= {22'h3FFFFF, 1'b0, 22'h40004};
        pulse(6'h20);
        pulse(6'h10);
        take(16'hFFF6, 16'h1233);
        pulse(6'h10);
        repeat (4) begin @(posedge clk_sys); #1 `CHK(core_ctl.take, 1'b0) end
        @(posedge clk_sys);
        pulse(6'h08);
        take(16'hFFF6, 16'h1233);  `CHK(disc, 1'b1)
        src_req <= 22'h40000;
        pulse(6'h08);
        take(16'hFFD6, 16'h1233);
        pulse(6'h01);
        take(16'hFFFC, 16'h1234);
        src_req <= 22'h0;
        pulse(6'h04);
        #1 `CHK({core_ctl.core_clk_en, core_ctl.periph_clk_en, watchdog_run}, 3'b011)
        @(posedge clk_sys);
        src_req <= 22'h1;
        take(16'hFFFA, 16'h1233);
        src_req <= 22'h0;
        pulse(6'h02);
        @(posedge clk_sys);
        #1 `CHK({core_ctl.core_clk_en, core_ctl.periph_clk_en}, 2'b00)
        src_req <= 22'h1;
        take(16'hFFFA, 16'h1233);
        src_req <= 22'h0;
        pulse(6'h04);
        break_req <= 1'b1;
        take(16'hFFFC, 16'h0);
        #1 `CHK(flag_clear_allow, 1'b0)
        @(posedge clk_sys);
        wb(1'b0, sim_irq_pkg::OFS_BREAK_STATE, 32'h0);  `CHK(rdat[1], 1'b1)
        wb(1'b1, sim_irq_pkg::OFS_BREAK_CTRL, 32'h80);  `CHK(flag_clear_allow, 1'b1)
        wb(1'b1, sim_irq_pkg::OFS_CORE_CTRL, 32'h1);    `CHK(watchdog_run, 1'b0)
        wb(1'b1, sim_irq_pkg::OFS_BREAK_STATE, 32'h0);
        wb(1'b0, sim_irq_pkg::OFS_BREAK_STATE, 32'h0);  `CHK(rdat[1], 1'b0)
        wb(1'b1, sim_irq_pkg::OFS_BREAK_CTRL, 32'h0);   `CHK(flag_clear_allow, 1'b0)
        {break_req, any_reset_req} <= 2'b01;
        @(posedge clk_sys);
        any_reset_req <= 1'b0;
        @(posedge clk_sys);
        #1 `CHK(core_ctl.vector, 16'hFFFE)
        `CHK(flag_clear_allow, 1'b1)
        end_sim();
    end
    initial
    begin
        repeat (3000) @(posedge clk_sys);
        fails++;
        end_sim();
    end
endmodule : sim_irq_ctrl_test
